// ### adcp_ctrl.sv
// Control and host-port logic of a 12-bit eight-channel successive-approximation converter.
// Assumes all host pins and the master clock are asynchronous to sys_clk (250 MHz),
// and the SAR core result is on sar_code_in in the sys_clk domain.
`timescale 1ns/10ps
`default_nettype none
`include "adcp_regs.svh"

// Behaviour
// [RULE1] Word-select high: transfers are one 16-bit word on all data pins.
// [RULE2] Word-select low: bytes on low pins, pin 8 picks high or low byte.
// [RULE3] Data pins drive only during a selected read, otherwise released.
// [RULE4] Result straight binary in unipolar range, two's complement in bipolar.
// [RULE5] Busy rises when conversion starts, stays high until it ends.
// [RULE6] Start pin rising edge puts track/hold in hold and begins conversion.
// [RULE7] Host ties the start pin low when unused.
// [RULE8] Write strobe with chip select low writes data into the converter.
// [RULE9] Read strobe with chip select low drives selected register on pins.
// [RULE10] Strobes are ignored while chip select is high.
// [RULE11] Track/hold returns to tracking when busy falls.
// [RULE12] Host leaves 400ns acquisition between busy falling and next start.
// [RULE13] Host supplies a 4MHz master clock that paces conversion.
// [RULE14] Channel select bits choose eight single-ended or four differential inputs.
// [RULE15] Conversion begins on next master falling edge, lasts 16.5 or 17.5 periods.
// [RULE16] In byte mode host writes low byte first, then high byte.
// [RULE17] Top two written bits address: 11 loads control, 00 writes nothing.
// [RULE18] Read select 00 returns result with four leading zeros, 11 returns status.
// [RULE19] Start requests while busy are ignored.
module adcp_ctrl #(
    parameter int RES_W = `ADCP_RES_W
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Host bus pins
    input wire logic chip_select_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic word_byte_select,
    input wire logic [15:0] data_pins_in,
    output logic [15:0] data_pins_out,
    output logic [15:0] data_pins_oe_n,
    // Conversion pins
    input wire logic conversion_start_pin,
    input wire logic master_clock_in,
    output logic busy,
    output logic hold,
    // SAR core
    input wire logic [RES_W-1:0] sar_code_in,
    // Analog front-end controls
    output logic [2:0] channel_select_bits,
    output logic single_ended_sel,
    output logic analog_mode,
    output logic [1:0] power_mgmt_bits
);
    // Elaboration check: the coding and read paths serve a 12-bit result only
    if (RES_W != 12)
    begin
        $error("adcp_ctrl serves a 12-bit result only");
    end

    adcp_pkg::adcp_bus_s bus_in;
    adcp_pkg::adcp_bus_s bus_s1_ff;
    adcp_pkg::adcp_bus_s bus_s2_ff;
    adcp_pkg::adcp_bus_s bus_q_ff;
    adcp_pkg::adcp_state_e state_ff;
    logic [2:0] start_sync_ff;
    logic [2:0] mclk_sync_ff;
    logic [`ADCP_CTRL_W-1:0] ctrl_ff;
    logic [7:0] low_byte_ff;
    logic [RES_W-1:0] result_ff;
    logic [2:0] setup_cnt_ff;
    logic [5:0] edge_cnt_ff;
    logic busy_ff;
    logic hold_ff;
    logic [15:0] data_out_ff;
    logic [15:0] data_oe_n_ff;
    logic wr_end;
    logic commit;
    logic [15:0] nxt_word;
    logic sw_start;
    logic start_req;
    logic mclk_fall;
    logic mclk_edge;
    logic conv_done;
    logic bipolar;
    logic rd_active;
    logic [15:0] rd_word;

    assign bus_in = '{chip_select_n, read_strobe_n, write_strobe_n, word_byte_select,
                      data_pins_in};

    // Two-stage synchronisers, plus one stage for edge detection
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            bus_s1_ff <= '{1'b1, 1'b1, 1'b1, 1'b1, 16'h0000};
            bus_s2_ff <= '{1'b1, 1'b1, 1'b1, 1'b1, 16'h0000};
            bus_q_ff <= '{1'b1, 1'b1, 1'b1, 1'b1, 16'h0000};
            start_sync_ff <= 3'h0;
            mclk_sync_ff <= 3'h0;
        end
        else
        begin
            bus_s1_ff <= bus_in;
            bus_s2_ff <= bus_s1_ff;
            bus_q_ff <= bus_s2_ff;
            start_sync_ff <= {start_sync_ff[1:0], conversion_start_pin};
            mclk_sync_ff <= {mclk_sync_ff[1:0], master_clock_in};
        end
    end

    // Write end detection and word assembly
    always_comb
    begin
        wr_end = !bus_q_ff.wr_n && bus_s2_ff.wr_n && !bus_q_ff.cs_n; // [RULE8] [RULE10]
        commit = 1'b0;
        nxt_word = bus_q_ff.data;
        if (wr_end)
        begin
            if (bus_q_ff.word_sel)
                commit = 1'b1; // [RULE1]
            else if (bus_q_ff.data[8])
            begin
                commit = 1'b1;
                nxt_word = {bus_q_ff.data[7:0], low_byte_ff}; // [RULE2] [RULE16]
            end
        end
    end

    assign sw_start = commit && (nxt_word[`ADCP_ADDR_HI:`ADCP_ADDR_LO] == `ADCP_ADDR_CTRL)
                      && nxt_word[`ADCP_START_BIT];
    assign start_req = (start_sync_ff[1] && !start_sync_ff[2]) || sw_start;
    assign mclk_fall = !mclk_sync_ff[1] && mclk_sync_ff[2];
    assign mclk_edge = mclk_sync_ff[1] ^ mclk_sync_ff[2];
    assign conv_done = (state_ff == adcp_pkg::ST_CONV) && mclk_edge
                       && (edge_cnt_ff == 6'(`ADCP_CONV_HALF_PERIODS - 1));
    assign bipolar = ctrl_ff[`ADCP_AMODE_BIT] && !ctrl_ff[`ADCP_SGLDIFF_BIT];

    // Low byte holding register for byte mode
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            low_byte_ff <= 8'h00;
        else if (wr_end && !bus_q_ff.word_sel && !bus_q_ff.data[8])
            low_byte_ff <= bus_q_ff.data[7:0]; // [RULE16]
    end

    // Control register; a write wins over the end-of-conversion clear
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            ctrl_ff <= `ADCP_CTRL_RESET;
        else if (commit && nxt_word[`ADCP_ADDR_HI:`ADCP_ADDR_LO] == `ADCP_ADDR_CTRL)
            ctrl_ff <= nxt_word[`ADCP_CTRL_W-1:0]; // [RULE17] [RULE14]
        else if (conv_done)
            ctrl_ff[`ADCP_START_BIT] <= 1'b0;
    end

    // Conversion sequencer
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_ff <= adcp_pkg::ST_IDLE;
            busy_ff <= 1'b0;
            hold_ff <= 1'b0;
            setup_cnt_ff <= 3'h0;
            edge_cnt_ff <= 6'h00;
        end
        else
        begin
            case (state_ff)
                adcp_pkg::ST_IDLE:
                begin
                    if (start_req) // [RULE19]
                    begin
                        state_ff <= adcp_pkg::ST_ARMED;
                        busy_ff <= 1'b1; // [RULE5]
                        hold_ff <= 1'b1; // [RULE6]
                        setup_cnt_ff <= 3'h0;
                    end
                end
                adcp_pkg::ST_ARMED:
                begin
                    // A falling edge too close to the request is skipped
                    if (mclk_fall && setup_cnt_ff >= 3'(`ADCP_SETUP_CYC))
                    begin
                        state_ff <= adcp_pkg::ST_CONV; // [RULE15]
                        edge_cnt_ff <= 6'h00;
                    end
                    else if (setup_cnt_ff != 3'h7)
                        setup_cnt_ff <= setup_cnt_ff + 3'h1;
                end
                adcp_pkg::ST_CONV:
                begin
                    if (conv_done)
                    begin
                        state_ff <= adcp_pkg::ST_IDLE;
                        busy_ff <= 1'b0;
                        hold_ff <= 1'b0; // [RULE11]
                    end
                    else if (mclk_edge)
                        edge_cnt_ff <= edge_cnt_ff + 6'h01; // [RULE15]
                end
                default:
                begin
                    state_ff <= adcp_pkg::ST_IDLE;
                    busy_ff <= 1'b0;
                    hold_ff <= 1'b0;
                end
            endcase
        end
    end

    // Result capture with output coding
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            result_ff <= '0;
        else if (conv_done)
            result_ff <= {sar_code_in[RES_W-1] ^ bipolar, sar_code_in[RES_W-2:0]}; // [RULE4]
    end

    // Read source selection
    always_comb
    begin
        if (ctrl_ff[`ADCP_RDSEL_HI:`ADCP_RDSEL_LO] == `ADCP_RDSEL_STATUS)
            rd_word = {busy_ff, hold_ff, ctrl_ff}; // [RULE18]
        else
            rd_word = {4'h0, result_ff}; // [RULE18]
    end

    assign rd_active = !bus_s2_ff.cs_n && !bus_s2_ff.rd_n; // [RULE9] [RULE10]

    // Data pin drivers
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            data_out_ff <= 16'h0000;
            data_oe_n_ff <= 16'hffff;
        end
        else if (rd_active && bus_s2_ff.word_sel)
        begin
            data_out_ff <= rd_word; // [RULE1]
            data_oe_n_ff <= 16'h0000;
        end
        else if (rd_active)
        begin
            data_out_ff <= {8'h00, bus_s2_ff.data[8] ? rd_word[15:8] : rd_word[7:0]}; // [RULE2]
            data_oe_n_ff <= 16'hff00;
        end
        else
            data_oe_n_ff <= 16'hffff; // [RULE3]
    end

    assign data_pins_out = data_out_ff;
    assign data_pins_oe_n = data_oe_n_ff;
    assign busy = busy_ff;
    assign hold = hold_ff;
    assign channel_select_bits = ctrl_ff[`ADCP_CHSEL_HI:`ADCP_CHSEL_LO];
    assign single_ended_sel = ctrl_ff[`ADCP_SGLDIFF_BIT];
    assign analog_mode = ctrl_ff[`ADCP_AMODE_BIT];
    assign power_mgmt_bits = ctrl_ff[`ADCP_PMGT_HI:`ADCP_PMGT_LO];

    // Checks
    AST_BUSY_HOLDS: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE5]
        busy_ff |-> hold_ff) else $error("busy high without hold");
    AST_START_RAISES: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE6]
        (state_ff == adcp_pkg::ST_IDLE) && start_req |=> busy_ff && hold_ff)
        else $error("start did not raise busy");
    AST_TRACK_ON_FALL: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE11]
        $fell(busy_ff) |-> !hold_ff && $past(conv_done)) else $error("track not at busy fall");
    AST_END_COUNT: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE15]
        $fell(busy_ff) |-> $past(edge_cnt_ff) == 6'h20) else $error("conversion length wrong");
    AST_IGNORE_START: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE19]
        (state_ff == adcp_pkg::ST_CONV) && !conv_done |=> busy_ff && $stable(result_ff))
        else $error("conversion disturbed");
    AST_NO_DRIVE_IDLE: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE3]
        bus_s2_ff.cs_n |=> data_oe_n_ff == 16'hffff) else $error("pins driven unselected");
    AST_CTRL_WRITE: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE17]
        commit && nxt_word[15:14] == 2'h3 |=> ctrl_ff == $past(nxt_word[13:0]))
        else $error("control write lost");
    AST_NULL_WRITE: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE17]
        commit && nxt_word[15:14] == 2'h0 && !conv_done |=> $stable(ctrl_ff))
        else $error("null address wrote");
    AST_READ_RESULT: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE18]
        rd_active && bus_s2_ff.word_sel && ctrl_ff[7:6] == 2'h0 |=> data_out_ff[15:12] == 4'h0
        && data_out_ff[11:0] == $past(result_ff)) else $error("result read wrong");
    AST_BIPOLAR_CODE: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE4]
        conv_done && bipolar |=> result_ff[11] == !$past(sar_code_in[11]))
        else $error("bipolar coding wrong");
    AST_BYTE_PINS: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE2]
        rd_active && !bus_s2_ff.word_sel |=> data_oe_n_ff == 16'hff00) else $error("byte pins");
endmodule
`default_nettype wire

// ### adcp_host_mdl.sv
// Host-side partner: 4 MHz master clock and data pin resolution.
// Assumes the bench drives host data and per-pin host enables.
`timescale 1ns/10ps
`default_nettype none
module adcp_host_mdl (
    // Bus sides
    input wire logic sys_clk,
    input wire logic [15:0] dut_out,
    input wire logic [15:0] dut_oe_n,
    input wire logic [15:0] host_d,
    input wire logic [15:0] host_oe,
    // Resolved pins and master clock
    output logic [15:0] pins,
    output logic mclk
);
    logic [15:0] last_ff = 16'h0000;
    // Free-running master clock
    initial
    begin
        mclk = 1'b0;
        forever #125 mclk = ~mclk;
    end
    // Undriven pins show the inverse of their last level
    always_comb
    begin
        for (int i = 0; i < 16; i++)
        begin
            pins[i] = !dut_oe_n[i] ? dut_out[i] : host_oe[i] ? host_d[i] : ~last_ff[i];
        end
    end
    // Remember the last level of every pin
    always @(posedge sys_clk)
        last_ff <= pins;
endmodule
`default_nettype wire

// ### adcp_pkg.sv
// Types shared by the converter port logic.
// Assumes adcp_regs.svh is on the include path.
`default_nettype none
`include "adcp_regs.svh"
package adcp_pkg;
    // Host bus pins as sampled
    typedef struct packed {
        logic cs_n;
        logic rd_n;
        logic wr_n;
        logic word_sel;
        logic [15:0] data;
    } adcp_bus_s;

    // Conversion sequencer, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ARMED = 3'b010,
        ST_CONV = 3'b100
    } adcp_state_e;
endpackage
`default_nettype wire

// ### adcp_regs.svh
// Offsets, field positions, reset values and timing counts of the converter port.
// Included by the package and the control module; definitions only.
`ifndef ADCP_REGS_SVH
`define ADCP_REGS_SVH

// Written word layout
`define ADCP_ADDR_HI 15
`define ADCP_ADDR_LO 14
`define ADCP_ADDR_CTRL 2'h3
`define ADCP_CTRL_W 14
`define ADCP_CTRL_RESET 14'h0000
// Control field positions
`define ADCP_START_BIT 4
`define ADCP_AMODE_BIT 5
`define ADCP_RDSEL_LO 6
`define ADCP_RDSEL_HI 7
`define ADCP_PMGT_LO 8
`define ADCP_PMGT_HI 9
`define ADCP_CHSEL_LO 10
`define ADCP_CHSEL_HI 12
`define ADCP_SGLDIFF_BIT 13
`define ADCP_RDSEL_STATUS 2'h3
// Timing
`define ADCP_CLK_NS 4
`define ADCP_SETUP_NS 10
`define ADCP_SETUP_CYC ((`ADCP_SETUP_NS + `ADCP_CLK_NS - 1) / `ADCP_CLK_NS)
`define ADCP_CONV_HALF_PERIODS 33
`define ADCP_RES_W 12

`endif

// ### tb_adc_parallel_port_conversion_ctrl.sv
// Bench for the converter port: host bus tasks and conversion checks.
// Assumes adcp_ctrl and adcp_host_mdl are compiled first.
`timescale 1ns/10ps
`default_nettype none
module tb_adc_parallel_port_conversion_ctrl;
    logic sys_clk, reset_n, cs_n, rd_n, wr_n, wsel, start, mclk, busy, hold, se, am;
    logic [15:0] host_d, host_oe, pins, dout, doe_n, v, oe;
    logic [2:0] chs;
    logic [1:0] pm;
    int n_fail, cmp_count, cyc, n;

    adcp_host_mdl host_u (.sys_clk(sys_clk), .dut_out(dout), .dut_oe_n(doe_n),
        .host_d(host_d), .host_oe(host_oe), .pins(pins), .mclk(mclk));
    adcp_ctrl #(.RES_W(12)) dut_u (.sys_clk(sys_clk), .reset_n(reset_n),
        .chip_select_n(cs_n), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
        .word_byte_select(wsel), .data_pins_in(pins), .data_pins_out(dout),
        .data_pins_oe_n(doe_n), .conversion_start_pin(start), .master_clock_in(mclk),
        .busy(busy), .hold(hold), .sar_code_in(12'h9a5), .channel_select_bits(chs),
        .single_ended_sel(se), .analog_mode(am), .power_mgmt_bits(pm));

    // Compare one value and count it
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e)
        begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Control fields as they should appear at the outputs
    function automatic logic [15:0] ctl(input logic [15:0] d);
        ctl = {9'h0, d[13], d[12:10], d[9:8], d[5]};
    endfunction
    // Host write: strobe held four cycles inside chip select
    task automatic wr(input logic c, input logic w, input logic [15:0] d);
        @(negedge sys_clk);
        cs_n = c;
        wsel = w;
        host_d = d;
        host_oe = 16'hffff;
        @(negedge sys_clk);
        wr_n = 1'b0;
        repeat (4) @(negedge sys_clk);
        wr_n = 1'b1;
        @(negedge sys_clk);
        cs_n = 1'b1;
        host_oe = 16'h0000;
        repeat (6) @(negedge sys_clk);
    endtask
    // Host read: pin 8 driven by the host in byte mode
    task automatic rd(input logic c, input logic w, input logic hb);
        @(negedge sys_clk);
        cs_n = c;
        wsel = w;
        host_d = {7'h00, hb, 8'h00};
        host_oe = w ? 16'h0000 : 16'h0100;
        rd_n = 1'b0;
        repeat (6) @(negedge sys_clk);
        v = pins;
        oe = doe_n;
        rd_n = 1'b1;
        cs_n = 1'b1;
        host_oe = 16'h0000;
        repeat (6) @(negedge sys_clk);
    endtask
    // One conversion; a second start pulse may be sent while busy
    task automatic conv(input logic hw, input logic extra);
        start = hw;
        n = 0;
        while (busy !== 1'b1 && n < 50)
        begin
            @(negedge sys_clk);
            n++;
        end
        chk("hold_at_start", 16'h1, {15'h0, hold});
        n = 0;
        while (busy === 1'b1 && n < 1200)
        begin
            @(negedge sys_clk);
            n++;
            if (n == 30 || n == 330)
                start = 1'b0;
            if (extra && n == 300)
                start = 1'b1;
        end
        chk("conv_len_ok", 16'h1, {15'h0, n >= 1025 && n <= 1110});
        chk("hold_after", 16'h0, {15'h0, hold});
        repeat (110) @(negedge sys_clk);
        chk("busy_idle", 16'h0, {15'h0, busy});
    endtask
    // Final report and verdict
    task automatic close_out();
        $display("Comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // 250 MHz clock
    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    // Hang guard
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_fail++;
            close_out();
        end
    end
    // Main sequence
    initial
    begin
        {cs_n, rd_n, wr_n, wsel} = 4'hf;
        start = 1'b0;
        host_d = 16'h0000;
        host_oe = 16'h0000;
        reset_n = 1'b0;
        repeat (10) @(negedge sys_clk);
        reset_n = 1'b1;
        chk("oe_reset", 16'hffff, doe_n);
        chk("ctl_reset", 16'h0000, {9'h0, se, chs, pm, am});
        $display("test reset done");
        wr(1'b0, 1'b1, 16'hf600);
        chk("ctl_word", ctl(16'hf600), {9'h0, se, chs, pm, am});
        wr(1'b1, 1'b1, 16'hc000);
        wr(1'b0, 1'b1, 16'h3fff);
        chk("ctl_kept", ctl(16'hf600), {9'h0, se, chs, pm, am});
        wr(1'b0, 1'b0, 16'h0020);
        chk("ctl_low_only", ctl(16'hf600), {9'h0, se, chs, pm, am});
        wr(1'b0, 1'b0, 16'h01c9);
        chk("ctl_bytes", ctl(16'hc920), {9'h0, se, chs, pm, am});
        $display("test writes done");
        conv(1'b1, 1'b1);
        rd(1'b0, 1'b1, 1'b0);
        chk("res_bipolar", 16'h01a5, v);
        chk("oe_word", 16'h0000, oe);
        $display("test bipolar done");
        wr(1'b0, 1'b1, 16'hf630); // range bit set with single-ended inputs stays unipolar
        conv(1'b0, 1'b0);
        rd(1'b0, 1'b1, 1'b0);
        chk("res_unipolar", 16'h09a5, v);
        rd(1'b0, 1'b0, 1'b1);
        chk("res_hi_byte", 16'h0009, {8'h00, v[7:0]});
        chk("oe_byte", 16'hff00, oe);
        rd(1'b0, 1'b0, 1'b0);
        chk("res_lo_byte", 16'h00a5, {8'h00, v[7:0]});
        $display("test unipolar done");
        wr(1'b0, 1'b1, 16'hf640);
        rd(1'b0, 1'b1, 1'b0);
        chk("res_sel01", 16'h09a5, v);
        wr(1'b0, 1'b1, 16'hf6c0);
        rd(1'b0, 1'b1, 1'b0);
        chk("status", 16'h36c0, v);
        rd(1'b1, 1'b1, 1'b0);
        chk("oe_unselected", 16'hffff, oe);
        $display("test status done");
        close_out();
    end
endmodule
`default_nettype wire
